/* hdl/ptbl_pkg.sv */
/*
  Constants and carrier types for the paper tape boot loader.
  Assumes a single 100 MHz clock and an active-low asynchronous reset.
*/
package ptbl_pkg;

  // ----------------------------------------
  // Sizes and layout
  // ----------------------------------------
  localparam int unsigned CHAR_W      = 8;
  localparam int unsigned WORD_W      = 32;
  localparam int unsigned DEV_ADDR_W  = 6;
  localparam int unsigned MEM_ADDR_W  = 16;
  localparam int unsigned CHAR_TOTAL  = 256;
  localparam int unsigned WORD_TOTAL  = 64;
  localparam int unsigned CHARS_PER_W = 4;
  localparam int unsigned CCNT_W      = 8;
  localparam int unsigned FIFO_DEPTH  = 16;

  // ----------------------------------------
  // Fixed values
  // ----------------------------------------
  localparam logic [DEV_ADDR_W-1:0] TAPE_CHANNEL   = 6'h00;
  localparam logic [CCNT_W-1:0]     CCNT_RESET     = 8'h00;
  localparam logic [CCNT_W-1:0]     CCNT_LAST      = 8'hFF;
  localparam logic [MEM_ADDR_W-1:0] TABLE_BASE_RST = 16'h0100;

  // Character arriving from the channel scanner
  typedef struct packed {
    logic [DEV_ADDR_W-1:0] dev_addr;
    logic [CHAR_W-1:0]     data;
  } ptbl_scan_char_t;

  // Word written into the buffer table
  typedef struct packed {
    logic [MEM_ADDR_W-1:0] addr;
    logic [WORD_W-1:0]     data;
  } ptbl_mem_wr_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_LOAD,
    ST_DRAIN,
    ST_START
  } ptbl_state_t;

  // Word address in the table (base plus word index) for a given character count
  function automatic logic [MEM_ADDR_W-1:0] word_addr(
    input logic [MEM_ADDR_W-1:0] base,
    input logic [CCNT_W-1:0]     ccnt
  );
    word_addr = base + {{(MEM_ADDR_W-CCNT_W+2){1'b0}}, ccnt[CCNT_W-1:2]};
  endfunction

endpackage

/* hdl/ptbl_fifo.sv */
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes the same clock and reset as its user.
*/
`timescale 1ns/100ps
module ptbl_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem_q[rd_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem_q[wr_q] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rstn)
    cnt_q <= DEPTH[AW:0])
    else $error("fifo count beyond depth");

endmodule

/* hdl/ptbl_packer.sv */
/*
  Packs four characters into one word, lowest character in the low byte.
  Assumes characters arrive in address order and clear precedes a load.
*/
`timescale 1ns/100ps
module ptbl_packer
  import ptbl_pkg::*;
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Control
  input  wire logic              clear,
  // Character in
  input  wire logic              char_en,
  input  wire logic [CHAR_W-1:0] char_data,
  input  wire logic [1:0]        char_lane,
  // Word out
  output logic                   word_done,
  output logic [WORD_W-1:0]      word_data
);
  logic [WORD_W-1:0] acc_q;
  logic              done_q;

  assign word_done = done_q;
  assign word_data = acc_q;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      acc_q  <= '0;
      done_q <= 1'b0;
    end
    else
    begin
      done_q <= char_en && (char_lane == 2'h3);
      if (clear)
      begin
        acc_q <= '0;
      end
      else if (char_en)
      begin
        acc_q[char_lane*CHAR_W +: CHAR_W] <= char_data;
      end
    end
  end

endmodule

/* hdl/ptbl_loader.sv */
/*
  Paper tape boot loader: on the load key, reads 256 tape characters,
  packs them into 64 buffer table words and starts the processor there.
  Assumes a valid/ready scanner and a memory that writes while mem_ready is high.
*/
`timescale 1ns/100ps
module ptbl_loader
  import ptbl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Operator console
  input  wire logic                  load_key,
  input  wire logic [MEM_ADDR_W-1:0] table_base,
  // Channel scanner
  input  wire logic                  scan_valid,
  output logic                       scan_ready,
  input  wire ptbl_scan_char_t       scan_char,
  output logic                       scan_lock,
  output logic [DEV_ADDR_W-1:0]      scan_channel,
  output logic                       reader_run,
  // Memory write port
  output logic                       mem_wr,
  output ptbl_mem_wr_t               mem_wr_pkt,
  input  wire logic                  mem_ready,
  // Processor control
  output logic                       load_lock,
  output logic                       char_count_mode,
  output logic                       pc_load,
  output logic [MEM_ADDR_W-1:0]      pc_value,
  output logic                       run_mode,
  output logic                       halt_light
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  ptbl_state_t           st_q;
  logic [CCNT_W-1:0]     input_table_location_counter_q;
  logic [MEM_ADDR_W-1:0] base_q;
  logic [6:0]            words_q;
  logic                  key_q;
  logic                  lock_q;
  logic                  reader_q;
  logic                  pc_load_q;
  logic [MEM_ADDR_W-1:0] pc_q;
  logic                  run_q;
  logic                  mem_wr_q;
  ptbl_mem_wr_t          mem_pkt_q;
  logic                  key_rise;
  logic                  take;
  logic                  feed;
  logic [CCNT_W-1:0]     fed_q;
  logic              f_out_valid;
  logic              f_out_ready;
  logic [CHAR_W-1:0] f_out_data;
  logic              f_in_ready;
  logic              w_done;
  logic [WORD_W-1:0] w_data;

  assign key_rise = load_key && !key_q;
  // ----------------------------------------
  // Character buffer
  // ----------------------------------------
  // only the character bits enter the buffer
  ptbl_fifo #(
    .WIDTH (CHAR_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rstn      (rstn),
    .in_valid  (scan_valid && reader_q),
    .in_ready  (f_in_ready),
    .in_data   (scan_char.data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // Memory back-pressure stalls the drain, so the FIFO can fill
  assign f_out_ready = (st_q == ST_LOAD || st_q == ST_DRAIN) && mem_ready && !mem_wr_q;
  assign take        = f_out_valid && f_out_ready;
  assign scan_ready  = f_in_ready && reader_q;
  assign feed        = scan_valid && scan_ready;

  ptbl_packer u_pack (
    .clk       (clk),
    .rstn      (rstn),
    .clear     (key_rise && !lock_q),
    .char_en   (take),
    .char_data (f_out_data),
    .char_lane (input_table_location_counter_q[1:0]),
    .word_done (w_done),
    .word_data (w_data)
  );

  // ----------------------------------------
  // Key edge
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      key_q <= 1'b0;
    end
    else
    begin
      key_q <= load_key;
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= ST_IDLE;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
        begin
          if (key_rise)
          begin
            st_q <= ST_LOAD;
          end
        end
        ST_LOAD:
        begin
          if (take && input_table_location_counter_q == CCNT_LAST)
          begin
            st_q <= ST_DRAIN;
          end
        end
        ST_DRAIN:
        begin
          // Wait for the last packed word to reach memory
          if (words_q == WORD_TOTAL[6:0] && !mem_wr_q)
          begin
            st_q <= ST_START;
          end
        end
        ST_START:
        begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Load lock and table base capture
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      lock_q <= 1'b0;
      base_q <= TABLE_BASE_RST;
    end
    else
    begin
      // lock on key, presses ignored while locked
      if (st_q == ST_IDLE && key_rise)
      begin
        lock_q <= 1'b1;
        base_q <= table_base;
      end
      else if (st_q == ST_START)
      begin
        lock_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Character address counter
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      input_table_location_counter_q <= CCNT_RESET;
    end
    else
    begin
      if (st_q == ST_IDLE && key_rise)
      begin
        input_table_location_counter_q <= CCNT_RESET;
      end
      // one step per character, upward from zero
      else if (take)
      begin
        input_table_location_counter_q <= input_table_location_counter_q + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Scanner and reader control
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      reader_q <= 1'b0;
      fed_q    <= CCNT_RESET;
    end
    else
    begin
      if (st_q == ST_IDLE && key_rise)
      begin
        reader_q <= 1'b1;
        fed_q    <= CCNT_RESET;
      end
      // stop at the 256th accepted character, so no spare ones sit in the FIFO
      else if (feed)
      begin
        fed_q <= fed_q + 8'h01;
        if (fed_q == CCNT_LAST)
        begin
          reader_q <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Word writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mem_wr_q  <= 1'b0;
      mem_pkt_q <= '0;
      words_q   <= '0;
    end
    else
    begin
      if (st_q == ST_IDLE && key_rise)
      begin
        words_q <= '0;
      end
      if (w_done)
      begin
        mem_wr_q       <= 1'b1;
        mem_pkt_q.data <= w_data;
        mem_pkt_q.addr <= word_addr(base_q, input_table_location_counter_q - 8'h01);
      end
      else if (mem_wr_q && mem_ready)
      begin
        mem_wr_q <= 1'b0;
        words_q  <= words_q + 7'h01;
      end
    end
  end

  // ----------------------------------------
  // Run control
  // ----------------------------------------
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pc_load_q <= 1'b0;
      pc_q      <= '0;
      run_q     <= 1'b0;
    end
    else
    begin
      pc_load_q <= 1'b0;
      // jump to table start; run, halt light off
      if (st_q == ST_START)
      begin
        pc_load_q <= 1'b1;
        pc_q      <= base_q;
        run_q     <= 1'b1;
      end
      else if (st_q == ST_IDLE && key_rise)
      begin
        run_q <= 1'b0;
      end
    end
  end

  assign scan_lock       = lock_q;
  assign scan_channel    = TAPE_CHANNEL;
  assign reader_run      = reader_q;
  assign mem_wr          = mem_wr_q;
  assign mem_wr_pkt      = mem_pkt_q;
  assign load_lock       = lock_q;
  assign char_count_mode = lock_q;
  assign pc_load         = pc_load_q;
  assign pc_value        = pc_q;
  assign run_mode        = run_q;
  assign halt_light      = !run_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  key_lock_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_IDLE && key_rise) |=> lock_q && input_table_location_counter_q == CCNT_RESET)
    else $error("load key did not lock and clear");
  scan_hold_a: assert property (@(posedge clk) disable iff (!rstn)
    reader_q |-> lock_q && scan_channel == TAPE_CHANNEL)
    else $error("reader running without scanner hold");
  char_step_a: assert property (@(posedge clk) disable iff (!rstn)
    take |=> input_table_location_counter_q == $past(input_table_location_counter_q) + 8'h01)
    else $error("counter did not step per character");
  lane_order_a: assert property (@(posedge clk) disable iff (!rstn)
    (take && input_table_location_counter_q[1:0] == 2'h0) |=>
      u_pack.acc_q[7:0] == $past(f_out_data))
    else $error("first character not in low lane");
  char_only_a: assert property (@(posedge clk) disable iff (!rstn)
    (w_done && !mem_wr_q) |=> mem_pkt_q.data == $past(w_data))
    else $error("stored word differs from packed characters");
  start_jump_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_START) |=> pc_load_q && pc_q == base_q && !lock_q && run_q)
    else $error("start did not jump and release");
  word_count_a: assert property (@(posedge clk) disable iff (!rstn)
    (st_q == ST_START) |-> words_q == WORD_TOTAL[6:0])
    else $error("wrong word total");
  run_light_a: assert property (@(posedge clk) disable iff (!rstn)
    halt_light == !run_mode)
    else $error("halt light disagrees with run mode");
  reader_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    (take && input_table_location_counter_q == CCNT_LAST) |=> !reader_q ##1 !reader_q)
    else $error("reader still running after last character");

endmodule

/* sim/ptbl_tape_model.sv */
/*
  Behavioural tape reader seen through the channel scanner.
  Assumes the loader holds reader_run and scan_lock while it wants characters.
*/
`timescale 1ns/100ps
module ptbl_tape_model
  import ptbl_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // Loader control
  input  wire logic                  reader_run,
  input  wire logic                  scan_lock,
  input  wire logic [DEV_ADDR_W-1:0] scan_channel,
  // Character stream
  output logic                       scan_valid,
  input  wire logic                  scan_ready,
  output ptbl_scan_char_t            scan_char,
  // Tape content and pacing
  input  wire logic [3:0]            gap,
  input  wire logic [CHAR_W-1:0]     seed,
  input  wire logic [DEV_ADDR_W-1:0] dev_noise
);
  logic [CHAR_W-1:0] idx_q;
  logic [3:0]        wait_q;
  logic              feeding;

  assign feeding = reader_run && scan_lock && (scan_channel == TAPE_CHANNEL);

  // ----------------------------------------
  // Tape transport
  // ----------------------------------------
  // Off the handshake the character lines toggle, so stale data never looks valid
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scan_valid <= 1'b0;
      idx_q      <= 8'h00;
      wait_q     <= 4'h0;
      scan_char  <= '1;
    end
    else if (!feeding)
    begin
      scan_valid <= 1'b0;
      idx_q      <= 8'h00;
      wait_q     <= 4'h0;
      scan_char  <= ~scan_char;
    end
    else if (scan_valid && scan_ready)
    begin
      idx_q      <= idx_q + 8'h01;
      wait_q     <= gap;
      scan_valid <= (gap == 4'h0);
      scan_char  <= (gap == 4'h0) ? {dev_noise, (idx_q + 8'h01) ^ seed} : ~scan_char;
    end
    else if (!scan_valid)
    begin
      if (wait_q != 4'h0)
      begin
        wait_q    <= wait_q - 4'h1;
        scan_char <= ~scan_char;
      end
      else
      begin
        scan_valid <= 1'b1;
        scan_char  <= {dev_noise, idx_q ^ seed};
      end
    end
  end
endmodule

/* sim/test_ptbl_loader.sv */
/*
  Self-checking bench for the paper tape boot loader.
  Assumes the tape model in the same folder and a 100 MHz clock.
*/
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((e) !== (g)) begin miscompares++; $display("mismatch %s expected %0h seen %0h", nm, (e), (g)); end end
module test_ptbl_loader;
  import ptbl_pkg::*;

  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                  clk = 1'b0;
  logic                  rstn = 1'b0;
  logic                  load_key = 1'b0;
  logic [MEM_ADDR_W-1:0] table_base = 16'h0000;
  logic                  scan_valid;
  logic                  scan_ready;
  ptbl_scan_char_t       scan_char;
  logic                  scan_lock;
  logic [DEV_ADDR_W-1:0] scan_channel;
  logic                  reader_run;
  logic                  mem_wr;
  ptbl_mem_wr_t          mem_wr_pkt;
  logic                  mem_ready = 1'b1;
  logic                  load_lock;
  logic                  char_count_mode;
  logic                  pc_load;
  logic [MEM_ADDR_W-1:0] pc_value;
  logic                  run_mode;
  logic                  halt_light;
  logic [3:0]            gap = 4'h0;
  logic [CHAR_W-1:0]     seed = 8'h00;
  logic [DEV_ADDR_W-1:0] dev_noise = 6'h00;
  logic                  stall = 1'b0;
  int                    cyc = 0;
  int                    n_char, n_pc, n_refused;
  int                    miscompares = 0;
  int                    n_compared = 0;
  logic [MEM_ADDR_W-1:0] pc_seen;
  ptbl_mem_wr_t          wr_q[$];

  always #5 clk = ~clk;

  ptbl_loader ptbl_loader_i (
    .clk(clk), .rstn(rstn), .load_key(load_key), .table_base(table_base),
    .scan_valid(scan_valid), .scan_ready(scan_ready), .scan_char(scan_char),
    .scan_lock(scan_lock), .scan_channel(scan_channel), .reader_run(reader_run),
    .mem_wr(mem_wr), .mem_wr_pkt(mem_wr_pkt), .mem_ready(mem_ready),
    .load_lock(load_lock), .char_count_mode(char_count_mode), .pc_load(pc_load),
    .pc_value(pc_value), .run_mode(run_mode), .halt_light(halt_light)
  );

  ptbl_tape_model ptbl_tape_model_i (
    .clk(clk), .rstn(rstn), .reader_run(reader_run), .scan_lock(scan_lock),
    .scan_channel(scan_channel), .scan_valid(scan_valid), .scan_ready(scan_ready),
    .scan_char(scan_char), .gap(gap), .seed(seed), .dev_noise(dev_noise)
  );

  // ----------------------------------------
  // Monitors, memory pacing and timeout
  // ----------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (scan_valid === 1'b1 && scan_ready === 1'b1)
      n_char++;
    if (scan_valid === 1'b1 && scan_ready === 1'b0 && reader_run === 1'b1)
      n_refused++;
    if (mem_wr === 1'b1 && mem_ready === 1'b1)
      wr_q.push_back(mem_wr_pkt);
    if (pc_load === 1'b1)
    begin
      n_pc++;
      pc_seen = pc_value;
    end
  end

  // A slow memory accepts one write in eight cycles, enough to back up the FIFO
  always @(posedge clk)
  begin
    #1;
    mem_ready = !stall || (cyc[2:0] == 3'h0);
  end

  always @(posedge clk)
  begin
    if (cyc == 20000)
    begin
      miscompares++;
      tally_and_finish();
    end
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check_reset();
    `CHK("halt_light", 1'b1, halt_light)
    `CHK("run_mode", 1'b0, run_mode)
    `CHK("load_lock", 1'b0, load_lock)
    `CHK("mem_wr", 1'b0, mem_wr)
  endtask

  task automatic run_load(input logic [15:0] base, input logic [7:0] sd, input logic [3:0] g,
                          input logic st, input logic [5:0] dn);
    int          i;
    int          j;
    logic [31:0] w;
    n_char = 0;
    n_pc = 0;
    n_refused = 0;
    wr_q.delete();
    @(posedge clk);
    #1;
    table_base = base;
    seed = sd;
    gap = g;
    stall = st;
    dev_noise = dn;
    load_key = 1'b1;
    i = 0;
    while (load_lock !== 1'b1 && i < 4)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    `CHK("load_lock", 1'b1, load_lock)
    `CHK("run_mode", 1'b0, run_mode)
    `CHK("char_count_mode", 1'b1, char_count_mode)
    `CHK("scan_lock", 1'b1, scan_lock)
    `CHK("scan_channel", TAPE_CHANNEL, scan_channel)
    `CHK("reader_run", 1'b1, reader_run)
    repeat (3) @(posedge clk);
    #1;
    load_key = 1'b0;
    // Second press while locked must change nothing
    repeat (20) @(posedge clk);
    #1;
    load_key = 1'b1;
    @(posedge clk);
    #1;
    load_key = 1'b0;
    i = 0;
    while (run_mode !== 1'b1 && i < 12000)
    begin
      @(posedge clk);
      #1;
      i++;
    end
    repeat (5) @(posedge clk);
    #1;
    `CHK("pc_load count", 1, n_pc)
    `CHK("pc_value", base, pc_seen)
    `CHK("run_mode", 1'b1, run_mode)
    `CHK("halt_light", 1'b0, halt_light)
    `CHK("load_lock", 1'b0, load_lock)
    `CHK("reader_run", 1'b0, reader_run)
    `CHK("chars", 256, n_char)
    `CHK("words", 64, wr_q.size())
    if (st)
      `CHK("fifo refusal", 1'b1, n_refused > 0)
    for (i = 0; i < 64 && i < wr_q.size(); i++)
    begin
      for (j = 0; j < 4; j++)
        w[8*j +: 8] = 8'(4*i + j) ^ sd;
      `CHK("word addr", 16'(base + i), wr_q[i].addr)
      `CHK("word data", w, wr_q[i].data)
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (4) @(posedge clk);
    #1;
    rstn = 1'b1;
    check_reset();
    run_load(16'h0100, 8'h00, 4'h0, 1'b0, 6'h00);
    run_load(16'h3FC0, 8'hA5, 4'h0, 1'b1, 6'h00);
    // Slow tape with junk in the address bits, which must not reach memory
    run_load(16'h0000, 8'h5A, 4'h3, 1'b0, 6'h3F);
    tally_and_finish();
  end
endmodule
